/* verilog/pwrseq_pkg.sv */
// constants shared by both ends of the power key / hard reset link
// assumes one 25 MHz clock on each end; times held in ms, counts derived
`default_nettype none

package pwrseq_pkg;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam logic [31:0] CLK_KHZ      = 32'h0000_61A8; // 25 MHz in kHz
    localparam logic [31:0] ON_MS        = 32'h0000_03E8; // 1000 ms
    localparam logic [31:0] ON_LOW_MS    = 32'h0000_1388; // 5000 ms
    localparam logic [31:0] CONFIRM_MS   = 32'h0000_0384; // 900 ms
    localparam logic [31:0] SERIAL_MS    = 32'h0000_00C8; // 200 ms
    localparam logic [31:0] OFF_MS       = 32'h0000_07D0; // 2000 ms
    localparam logic [31:0] RST_MS       = 32'h0000_00C8; // 200 ms
    localparam logic [31:0] TIMEOUT_MS   = 32'h0000_2710; // 10000 ms

    localparam logic [31:0] ON_CYC       = ON_MS * CLK_KHZ;
    localparam logic [31:0] ON_LOW_CYC   = ON_LOW_MS * CLK_KHZ;
    localparam logic [31:0] CONFIRM_CYC  = CONFIRM_MS * CLK_KHZ;
    localparam logic [31:0] SERIAL_CYC   = SERIAL_MS * CLK_KHZ;
    localparam logic [31:0] OFF_CYC      = OFF_MS * CLK_KHZ;
    localparam logic [31:0] RST_CYC      = RST_MS * CLK_KHZ;
    localparam logic [31:0] TIMEOUT_CYC  = TIMEOUT_MS * CLK_KHZ;

    // device-side internal durations, in cycles
    localparam logic [31:0] DETACH_CYC   = 32'h0000_0010;
    localparam logic [31:0] REBOOT_CYC   = 32'h0000_0040;
    localparam logic [31:0] CNT_MAX      = 32'hFFFF_FFFF;

    // -------------------------------------------------------------------
    // states
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {DEV_OFF, DEV_ON, DEV_SHUT, DEV_BOOT} pwrseq_dev_t;
    typedef enum logic [2:0] {
        HOST_IDLE, HOST_ONKEY, HOST_ONWAIT, HOST_OFFKEY,
        HOST_OFFWAIT, HOST_RSTKEY, HOST_RSTWAIT
    } pwrseq_host_t;

endpackage

`default_nettype wire

/* verilog/pwrseq_if.sv */
// pin bundle between host sequencer and module
// assumes testbench instantiates it and hooks both ends
`timescale 1ns/10ps
`default_nettype none

interface pwrseq_if;
    logic keyOut;        // host key driver level
    logic keyOe;         // host pulls key line
    logic powerKeyN;     // resolved key line
    logic rstOut;        // host reset driver level
    logic rstOe;         // host pulls reset line
    logic hardResetN;    // resolved reset line
    logic powerMonitor;  // module power state
    logic serialTx;      // host serial data to module

    // -------------------------------------------------------------------
    // open-collector resolution with internal pull-ups
    // -------------------------------------------------------------------
    assign powerKeyN  = ~(keyOe & ~keyOut);
    assign hardResetN = ~(rstOe & ~rstOut);

    modport host (
        output keyOut, keyOe, rstOut, rstOe, serialTx,
        input  powerKeyN, hardResetN, powerMonitor
    );
    modport device (
        input  powerKeyN, hardResetN,
        output powerMonitor
    );
endinterface

`default_nettype wire

/* verilog/pwrseq_device.sv */
// module end: power state machine behind the key and reset pins
// assumes pins arrive asynchronously and host keeps pulse widths
`timescale 1ns/10ps
`default_nettype none

module pwrseq_device #(
    parameter logic [31:0] ON_CYC     = pwrseq_pkg::ON_CYC,
    parameter logic [31:0] ON_LOW_CYC = pwrseq_pkg::ON_LOW_CYC,
    parameter logic [31:0] OFF_CYC    = pwrseq_pkg::OFF_CYC,
    parameter logic [31:0] RST_CYC    = pwrseq_pkg::RST_CYC,
    parameter logic        SHORT_OFF  = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst,
    pwrseq_if.device  pins,
    input  wire logic lowSupply,
    input  wire logic softShutdown,
    output logic      isOn,
    output logic      detachReq,
    output logic      rebooted
);
    pwrseq_pkg::pwrseq_dev_t state_ff, nxt_state;
    logic [31:0] keyCnt_ff, rstCnt_ff, timer_ff;
    logic        keyS1_ff, keyS2_ff, rstS1_ff, rstS2_ff;
    logic        keyWasLow_ff, rstWasLow_ff;
    logic        monitor_ff, detach_ff, reboot_ff;

    // -------------------------------------------------------------------
    // pin synchronisers and low-time counters
    // -------------------------------------------------------------------
    wire logic        keyLow     = ~keyS2_ff;
    wire logic        rstLow     = ~rstS2_ff;
    wire logic        keyRelease = keyWasLow_ff & ~keyLow;
    wire logic        rstRelease = rstWasLow_ff & ~rstLow;
    wire logic [31:0] onNeed     = lowSupply ? ON_LOW_CYC : ON_CYC;
    wire logic        onPulse    = keyRelease & (keyCnt_ff >= onNeed);
    wire logic        offPulse   = keyRelease & ((keyCnt_ff >= OFF_CYC)
                                   | (SHORT_OFF & (keyCnt_ff != 32'h0000_0000)));
    wire logic        rstPulse   = rstRelease & (rstCnt_ff >= RST_CYC);
    wire logic        timerHit   = (state_ff == pwrseq_pkg::DEV_SHUT)
                                   ? (timer_ff >= pwrseq_pkg::DETACH_CYC)
                                   : (timer_ff >= pwrseq_pkg::REBOOT_CYC);

    // sync chains, first stage read only by second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyS1_ff     <= 1'b1;
            keyS2_ff     <= 1'b1;
            rstS1_ff     <= 1'b1;
            rstS2_ff     <= 1'b1;
            keyWasLow_ff <= 1'b0;
            rstWasLow_ff <= 1'b0;
        end else begin
            keyS1_ff     <= pins.powerKeyN;
            keyS2_ff     <= keyS1_ff;
            rstS1_ff     <= pins.hardResetN;
            rstS2_ff     <= rstS1_ff;
            keyWasLow_ff <= keyLow;
            rstWasLow_ff <= rstLow;
        end
    end

    // saturating low-time counters, cleared once the line is high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyCnt_ff <= 32'h0000_0000;
            rstCnt_ff <= 32'h0000_0000;
        end else begin
            keyCnt_ff <= !keyLow ? 32'h0000_0000
                       : (keyCnt_ff == pwrseq_pkg::CNT_MAX) ? keyCnt_ff
                       : keyCnt_ff + 32'h0000_0001;
            rstCnt_ff <= !rstLow ? 32'h0000_0000
                       : (rstCnt_ff == pwrseq_pkg::CNT_MAX) ? rstCnt_ff
                       : rstCnt_ff + 32'h0000_0001;
        end
    end

    // -------------------------------------------------------------------
    // power state machine
    // -------------------------------------------------------------------
    // key and reset decisions taken on release only, never while held low
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pwrseq_pkg::DEV_OFF: begin
                if (onPulse) begin
                    nxt_state = pwrseq_pkg::DEV_ON;
                end
            end
            pwrseq_pkg::DEV_ON: begin
                if (rstPulse) begin
                    nxt_state = pwrseq_pkg::DEV_BOOT;
                end else if (softShutdown | offPulse) begin
                    nxt_state = pwrseq_pkg::DEV_SHUT;
                end
            end
            pwrseq_pkg::DEV_SHUT: begin
                if (rstPulse) begin
                    nxt_state = pwrseq_pkg::DEV_BOOT;
                end else if (timerHit) begin
                    nxt_state = pwrseq_pkg::DEV_OFF;
                end
            end
            pwrseq_pkg::DEV_BOOT: begin
                if (timerHit) begin
                    nxt_state = pwrseq_pkg::DEV_ON;
                end
            end
            default: nxt_state = pwrseq_pkg::DEV_OFF;
        endcase
    end

    // state, timer and registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff   <= pwrseq_pkg::DEV_OFF;
            timer_ff   <= 32'h0000_0000;
            monitor_ff <= 1'b0;
            detach_ff  <= 1'b0;
            reboot_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            timer_ff   <= (nxt_state != state_ff) ? 32'h0000_0000 : timer_ff + 32'h0000_0001;
            monitor_ff <= (nxt_state == pwrseq_pkg::DEV_ON)
                        | (nxt_state == pwrseq_pkg::DEV_SHUT);
            detach_ff  <= (nxt_state == pwrseq_pkg::DEV_SHUT)
                        & (state_ff != pwrseq_pkg::DEV_SHUT);
            reboot_ff  <= (state_ff == pwrseq_pkg::DEV_BOOT)
                        & (nxt_state == pwrseq_pkg::DEV_ON);
        end
    end

    assign pins.powerMonitor = monitor_ff;
    assign isOn              = monitor_ff;
    assign detachReq         = detach_ff;
    assign rebooted          = reboot_ff;
endmodule

`default_nettype wire

/* verilog/pwrseq_host.sv */
// host end: drives key and reset pulses, watches the power monitor
// assumes monitor pin is asynchronous; user requests on own clock
`timescale 1ns/10ps
`default_nettype none

module pwrseq_host #(
    parameter logic [31:0] ON_CYC      = pwrseq_pkg::ON_CYC,
    parameter logic [31:0] ON_LOW_CYC  = pwrseq_pkg::ON_LOW_CYC,
    parameter logic [31:0] OFF_CYC     = pwrseq_pkg::OFF_CYC,
    parameter logic [31:0] RST_CYC     = pwrseq_pkg::RST_CYC,
    parameter logic [31:0] CONFIRM_CYC = pwrseq_pkg::CONFIRM_CYC,
    parameter logic [31:0] SERIAL_CYC  = pwrseq_pkg::SERIAL_CYC,
    parameter logic [31:0] TIMEOUT_CYC = pwrseq_pkg::TIMEOUT_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    pwrseq_if.host    pins,
    input  wire logic powerOnReq,
    input  wire logic powerOffReq,
    input  wire logic hardResetReq,
    input  wire logic lowSupply,
    input  wire logic txData,
    output logic      busy,
    output logic      moduleOn,
    output logic      serialOk,
    output logic      done,
    output logic      timedOut
);
    pwrseq_pkg::pwrseq_host_t state_ff, nxt_state;
    logic [31:0] timer_ff;
    logic [31:0] highCnt_ff;
    logic        monS1_ff, monS2_ff;
    logic        keyOe_ff, rstOe_ff;
    logic        moduleOn_ff, serialOk_ff, tx_ff;
    logic        done_ff, timedOut_ff;

    // -------------------------------------------------------------------
    // state decode
    // -------------------------------------------------------------------
    wire logic monHigh   = monS2_ff;
    wire logic inKey     = (state_ff == pwrseq_pkg::HOST_ONKEY)
                         | (state_ff == pwrseq_pkg::HOST_OFFKEY)
                         | (state_ff == pwrseq_pkg::HOST_RSTKEY);
    wire logic inWait    = (state_ff == pwrseq_pkg::HOST_ONWAIT)
                         | (state_ff == pwrseq_pkg::HOST_OFFWAIT)
                         | (state_ff == pwrseq_pkg::HOST_RSTWAIT);
    wire logic idle      = (state_ff == pwrseq_pkg::HOST_IDLE);
    wire logic confirmed = (highCnt_ff >= CONFIRM_CYC);
    wire logic waitOver  = (timer_ff >= TIMEOUT_CYC);

    // pulse length of the current key or reset pulse, minus one
    wire logic [31:0] onNeed  = lowSupply ? ON_LOW_CYC : ON_CYC;
    wire logic [31:0] keyNeed = (state_ff == pwrseq_pkg::HOST_ONKEY)  ? onNeed
                              : (state_ff == pwrseq_pkg::HOST_OFFKEY) ? OFF_CYC
                              : RST_CYC;
    wire logic        keyEnd  = (timer_ff == (keyNeed - 32'h0000_0001));

    // -------------------------------------------------------------------
    // monitor synchroniser and high-time counter
    // -------------------------------------------------------------------
    // two flops before any logic looks at the pin
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            monS1_ff <= 1'b0;
            monS2_ff <= 1'b0;
        end else begin
            monS1_ff <= pins.powerMonitor;
            monS2_ff <= monS1_ff;
        end
    end

    // restarted by every pulse so a stale high cannot confirm
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            highCnt_ff <= 32'h0000_0000;
        end else if (!monHigh || inKey) begin
            highCnt_ff <= 32'h0000_0000;
        end else if (!confirmed) begin
            highCnt_ff <= highCnt_ff + 32'h0000_0001;
        end
    end

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    // requests accepted only when idle; reset beats off beats on
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pwrseq_pkg::HOST_IDLE: begin
                if (hardResetReq && monHigh) begin
                    nxt_state = pwrseq_pkg::HOST_RSTKEY;
                end else if (powerOffReq && monHigh) begin
                    nxt_state = pwrseq_pkg::HOST_OFFKEY;
                end else if (powerOnReq && !monHigh) begin
                    nxt_state = pwrseq_pkg::HOST_ONKEY;
                end
            end
            pwrseq_pkg::HOST_ONKEY: begin
                if (keyEnd) begin
                    nxt_state = pwrseq_pkg::HOST_ONWAIT;
                end
            end
            pwrseq_pkg::HOST_OFFKEY: begin
                if (keyEnd) begin
                    nxt_state = pwrseq_pkg::HOST_OFFWAIT;
                end
            end
            pwrseq_pkg::HOST_RSTKEY: begin
                if (keyEnd) begin
                    nxt_state = pwrseq_pkg::HOST_RSTWAIT;
                end
            end
            pwrseq_pkg::HOST_ONWAIT,
            pwrseq_pkg::HOST_RSTWAIT: begin
                if (confirmed || waitOver) begin
                    nxt_state = pwrseq_pkg::HOST_IDLE;
                end
            end
            pwrseq_pkg::HOST_OFFWAIT: begin
                if (!monHigh || waitOver) begin
                    nxt_state = pwrseq_pkg::HOST_IDLE;
                end
            end
            default: nxt_state = pwrseq_pkg::HOST_IDLE;
        endcase
    end

    // completion flags for the user side
    wire logic leaving  = inWait & (nxt_state == pwrseq_pkg::HOST_IDLE);
    wire logic goodEnd  = (state_ff == pwrseq_pkg::HOST_OFFWAIT) ? !monHigh : confirmed;

    // state and pulse timer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= pwrseq_pkg::HOST_IDLE;
            timer_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= (nxt_state != state_ff) ? 32'h0000_0000 : timer_ff + 32'h0000_0001;
        end
    end

    // -------------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------------
    // pulls low only; release leaves the line to the pull-up
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyOe_ff <= 1'b0;
            rstOe_ff <= 1'b0;
        end else begin
            keyOe_ff <= (nxt_state == pwrseq_pkg::HOST_ONKEY)
                      | (nxt_state == pwrseq_pkg::HOST_OFFKEY);
            rstOe_ff <= (nxt_state == pwrseq_pkg::HOST_RSTKEY);
        end
    end

    assign pins.keyOut = 1'b0;
    assign pins.keyOe  = keyOe_ff;
    assign pins.rstOut = 1'b0;
    assign pins.rstOe  = rstOe_ff;

    // serial gate: low while off, starting up or in transition
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serialOk_ff <= 1'b0;
            tx_ff       <= 1'b0;
        end else begin
            serialOk_ff <= idle & (highCnt_ff >= SERIAL_CYC);
            tx_ff       <= serialOk_ff & txData;
        end
    end

    assign pins.serialTx = tx_ff;

    // -------------------------------------------------------------------
    // user status
    // -------------------------------------------------------------------
    // done and timedOut pulse once as a wait ends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            moduleOn_ff <= 1'b0;
            done_ff     <= 1'b0;
            timedOut_ff <= 1'b0;
        end else begin
            moduleOn_ff <= monHigh & confirmed & !inKey;
            done_ff     <= leaving & goodEnd;
            timedOut_ff <= leaving & !goodEnd;
        end
    end

    assign busy     = !idle;
    assign moduleOn = moduleOn_ff;
    assign serialOk = serialOk_ff;
    assign done     = done_ff;
    assign timedOut = timedOut_ff;
endmodule

`default_nettype wire

/* testbench/pwrseq_sva.sv */
// checker for the key, reset, monitor and serial pins between both ends
// assumes tb instantiates it beside the pin bundle; pulse counts passed in
`timescale 1ns/10ps
`default_nettype none

module pwrseq_sva #(
    parameter logic [31:0] ON_CYC     = 32'h0000_0028,
    parameter logic [31:0] ON_LOW_CYC = 32'h0000_0064,
    parameter logic [31:0] OFF_CYC    = 32'h0000_003C,
    parameter logic [31:0] RST_CYC    = 32'h0000_0014
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic keyOut,
    input wire logic keyOe,
    input wire logic powerKeyN,
    input wire logic rstOut,
    input wire logic rstOe,
    input wire logic hardResetN,
    input wire logic powerMonitor,
    input wire logic serialTx
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [31:0] keyCnt_ff;
    logic [31:0] rstCnt_ff;
    logic [31:0] nxt_keyCnt;
    logic [31:0] nxt_rstCnt;

    // run length of each pulled line
    assign nxt_keyCnt = keyOe ? keyCnt_ff + 32'h0000_0001 : 32'h0000_0000;
    assign nxt_rstCnt = rstOe ? rstCnt_ff + 32'h0000_0001 : 32'h0000_0000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keyCnt_ff <= 32'h0000_0000;
            rstCnt_ff <= 32'h0000_0000;
        end else begin
            keyCnt_ff <= nxt_keyCnt;
            rstCnt_ff <= nxt_rstCnt;
        end
    end

    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // module answers after the line is let go
    sequence onSeq;
        ##[2:8] powerMonitor;
    endsequence
    sequence offSeq;
        powerMonitor [*8] ##[6:20] !powerMonitor;
    endsequence
    sequence bootSeq;
        ##[1:6] !powerMonitor [*8] ##[50:66] powerMonitor;
    endsequence

    key_oc_a: assert property (keyOut == 1'b0)
        else $error("key driven high");
    rst_oc_a: assert property (rstOut == 1'b0)
        else $error("reset driven high");
    on_width_a: assert property ($fell(keyOe) && !powerMonitor |->
        keyCnt_ff == ON_CYC || keyCnt_ff == ON_LOW_CYC)
        else $error("power-on pulse width wrong");
    off_width_a: assert property ($fell(keyOe) && powerMonitor |->
        keyCnt_ff == OFF_CYC)
        else $error("power-off pulse width wrong");
    rst_width_a: assert property ($fell(rstOe) |-> rstCnt_ff == RST_CYC)
        else $error("reset pulse width wrong");
    off_hold_a: assert property (!powerKeyN && powerMonitor |=> powerMonitor)
        else $error("shutdown while key held");
    on_answer_a: assert property ($fell(keyOe) && keyCnt_ff == ON_LOW_CYC |-> onSeq)
        else $error("module did not power on");
    off_answer_a: assert property ($fell(keyOe) && powerMonitor |-> offSeq)
        else $error("module did not power off");
    boot_answer_a: assert property ($fell(rstOe) && powerMonitor |-> bootSeq)
        else $error("module did not reboot");
    off_spacing_a: assert property ($fell(keyOe) && powerMonitor |->
        !(keyOe || rstOe) until !powerMonitor)
        else $error("new pulse before off confirmed");
    serial_start_a: assert property ($rose(powerMonitor) |-> !serialTx [*8])
        else $error("serial data right after start");
    serial_gate_a: assert property ((keyOe || rstOe) [*3] or !powerMonitor [*8]
        |-> !serialTx)
        else $error("serial data during transition");
endmodule

`default_nettype wire

/* testbench/tb.sv */
// self-checking bench: host and module ends joined by the pin bundle
// assumes shortened counts; inputs driven on the falling clock edge
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module tb;
    localparam logic [31:0] ON  = 32'h0000_0028;
    localparam logic [31:0] ONL = 32'h0000_0064;
    localparam logic [31:0] OFF = 32'h0000_003C;
    localparam logic [31:0] RST = 32'h0000_0014;
    localparam logic [31:0] CNF = 32'h0000_001E;

    logic        clock, rst, powerOnReq, powerOffReq, hardResetReq, softShutdown;
    logic        lowHost, lowDev, txData, busy, moduleOn, serialOk, done, timedOut;
    logic        isOn, detachReq, rebooted;
    logic [31:0] keyLen, rstLen, detN, bootN, doneN, toN, monN;
    int          fails, checks;

    pwrseq_if pins();
    pwrseq_device #(.ON_CYC(ON), .ON_LOW_CYC(ONL), .OFF_CYC(OFF), .RST_CYC(RST))
    i_pwrseq_device (.clock(clock), .rst(rst), .pins(pins), .lowSupply(lowDev),
        .softShutdown(softShutdown), .isOn(isOn), .detachReq(detachReq),
        .rebooted(rebooted));
    pwrseq_host #(.ON_CYC(ON), .ON_LOW_CYC(ONL), .OFF_CYC(OFF), .RST_CYC(RST),
        .CONFIRM_CYC(CNF), .SERIAL_CYC(32'h0000_000A), .TIMEOUT_CYC(32'h0000_01F4))
    i_pwrseq_host (.clock(clock), .rst(rst), .pins(pins), .powerOnReq(powerOnReq),
        .powerOffReq(powerOffReq), .hardResetReq(hardResetReq), .lowSupply(lowHost),
        .txData(txData), .busy(busy), .moduleOn(moduleOn), .serialOk(serialOk),
        .done(done), .timedOut(timedOut));
    pwrseq_sva #(.ON_CYC(ON), .ON_LOW_CYC(ONL), .OFF_CYC(OFF), .RST_CYC(RST))
    i_pwrseq_sva (.clock(clock), .rst(rst), .keyOut(pins.keyOut), .keyOe(pins.keyOe),
        .powerKeyN(pins.powerKeyN), .rstOut(pins.rstOut), .rstOe(pins.rstOe),
        .hardResetN(pins.hardResetN), .powerMonitor(pins.powerMonitor),
        .serialTx(pins.serialTx));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] add1(input logic [31:0] v, input logic b);
        return v + {31'h0000_0000, b};
    endfunction

    // one request, then count high cycles of each signal until done, timeout or limit
    task automatic run(input int which, input int lim);
        int n;
        {keyLen, rstLen, detN, bootN, doneN, toN, monN} = '0;
        @(negedge clock);
        powerOnReq = (which == 0);
        powerOffReq = (which == 1);
        hardResetReq = (which == 2);
        softShutdown = (which == 3);
        for (n = 0; n < lim; n++) begin
            @(negedge clock);
            {powerOnReq, powerOffReq, hardResetReq, softShutdown} = 4'h0;
            keyLen = add1(keyLen, pins.keyOe);
            rstLen = add1(rstLen, pins.rstOe);
            detN = add1(detN, detachReq);
            bootN = add1(bootN, rebooted);
            doneN = add1(doneN, done);
            toN = add1(toN, timedOut);
            monN = add1(monN, pins.powerMonitor);
            if (done === 1'b1 || timedOut === 1'b1) break;
        end
    endtask

    task automatic endt(input string nm);
        $display("test %s finished, fails %0d", nm, fails);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_of_test();
    end

    // main sequence
    initial begin
        {rst, powerOnReq, powerOffReq, hardResetReq, softShutdown} = 5'h1F;
        {powerOnReq, powerOffReq, hardResetReq, softShutdown} = 4'h0;
        {lowHost, lowDev, txData} = 3'h2;
        fails = 0;
        checks = 0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        `CHK("monitor after reset", 1'b0, pins.powerMonitor)
        run(0, 700);
        `CHK("short on width", ON, keyLen)
        `CHK("refused on timeout", 32'h0000_0001, toN)
        `CHK("refused on done", 32'h0000_0000, doneN)
        `CHK("refused on monitor", 1'b0, pins.powerMonitor)
        endt("refused_on");
        lowHost = 1'b1;
        run(0, 700);
        `CHK("low supply width", ONL, keyLen)
        `CHK("low supply done", 32'h0000_0001, doneN)
        `CHK("low supply on", 1'b1, moduleOn)
        endt("low_supply_on");
        {lowHost, lowDev} = 2'h0;
        run(2, 700);
        `CHK("reset width", RST, rstLen)
        `CHK("reboot detach", 32'h0000_0000, detN)
        `CHK("reboot pulse", 32'h0000_0001, bootN)
        `CHK("reboot done", 32'h0000_0001, doneN)
        `CHK("reboot idle", 1'b0, busy)
        `CHK("on after reboot", 1'b1, moduleOn)
        endt("reboot");
        run(3, 80);
        `CHK("soft detach", 32'h0000_0001, detN)
        `CHK("soft monitor", 1'b0, pins.powerMonitor)
        `CHK("soft isOn", 1'b0, isOn)
        endt("soft_off");
        run(0, 700);
        `CHK("on width", ON, keyLen)
        `CHK("on done", 32'h0000_0001, doneN)
        `CHK("confirm span", 1'b1, monN >= CNF)
        `CHK("module on", 1'b1, moduleOn)
        txData = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("serial allowed", 1'b1, serialOk)
        `CHK("serial passes", 1'b1, pins.serialTx)
        endt("normal_on");
        run(1, 700);
        `CHK("off width", OFF, keyLen)
        `CHK("off detach", 32'h0000_0001, detN)
        `CHK("off done", 32'h0000_0001, doneN)
        `CHK("off no timeout", 32'h0000_0000, toN)
        `CHK("off monitor", 1'b0, pins.powerMonitor)
        `CHK("off moduleOn", 1'b0, moduleOn)
        `CHK("serial gated", 1'b0, pins.serialTx)
        endt("key_off");
        run(2, 20);
        `CHK("reset while off", 32'h0000_0000, rstLen)
        `CHK("idle while off", 1'b0, busy)
        run(1, 20);
        `CHK("off while off", 32'h0000_0000, keyLen)
        endt("ignored");
        end_of_test();
    end
endmodule

`default_nettype wire
